//--- rtl/hmfdc_map.svh
// Register map, field positions, reset values and the history depth for the
// host MAC FIFO datapath control block.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
//
// Function
// RL1: The start of valid receive data is shifted by the five-bit receive byte offset, any value from 0 to 31.
// RL2: The host changes the two low offset bits only while the receiver is halted and its data purged.
// RL3: The three upper, word-granular offset bits may change while receiving and apply from the next word read.
// RL4: Writing one to the status flush bit empties the transmit status FIFO, zeroes its pointers and self-clears.
// RL5: Writing one to the data flush bit empties the transmit data FIFO and zeroes its pointers.
// RL6: With overrun permit clear a full status FIFO suspends transmission; with it set transmission continues.
// RL7: The status-FIFO-full interrupt works the same whatever the overrun permit says.
// RL8: While the transmitter enable bit is set the MAC transmitter runs and sends queued frame data.
// RL9: The transmitter enable bit clears itself once a stop was requested and the transmitter has halted.
// RL10: A stop request lets the current frame finish, then transmission ceases and the stop bit self-clears.
// RL11: While the stop bit reads high every write to it is ignored.
// RL12: Writing one to the frame skip bit advances the receive data FIFO to the next frame; it stays high until done.
// RL13: The host should not read the receive data FIFO while the frame skip bit reads high.
// RL14: Reserved bits read as zero and writes to them are discarded.
`ifndef HMFDC_MAP_SVH
`define HMFDC_MAP_SVH

`define HMFDC_ADDR_W          12
`define HMFDC_RX_CFG_OFF      12'h06C
`define HMFDC_TX_CFG_OFF      12'h070
`define HMFDC_RECEIVE_DATAPATH_CONTROL_OFF  12'h078
`define HMFDC_IRQ_STS_OFF     12'h0C0
`define HMFDC_IRQ_MASK_OFF    12'h0C4

`define HMFDC_RXOFF_LSB       8
`define HMFDC_RXOFF_MSB       12
`define HMFDC_TX_STS_FLUSH    15
`define HMFDC_TX_DAT_FLUSH    14
`define HMFDC_TX_OVR_PERMIT   2
`define HMFDC_TX_ENABLE       1
`define HMFDC_TX_STOP         0
`define HMFDC_RX_SKIP         31

`define HMFDC_IRQ_STS_FULL    0
`define HMFDC_IRQ_TX_STOPPED  1
`define HMFDC_IRQ_SKIP_DONE   2
`define HMFDC_IRQ_W           3

`define HMFDC_RXOFF_RST       5'h00
`define HMFDC_IRQ_MASK_RST    3'h0
`define HMFDC_HIST_DEPTH      4

`endif

//--- rtl/hmfdc_pkg.sv
// Types shared by the host MAC FIFO datapath control block.
// Assumes the constants of hmfdc_map.svh.
package hmfdc_pkg;

    typedef enum logic [1:0] {
        HMFDC_TX_IDLE = 2'b00,
        HMFDC_TX_RUN  = 2'b01,
        HMFDC_TX_STOP = 2'b10
    } hmfdc_tx_state_type;

    typedef enum logic [0:0] {
        HMFDC_SKIP_IDLE = 1'b0,
        HMFDC_SKIP_BUSY = 1'b1
    } hmfdc_skip_state_type;

endpackage

//--- rtl/hmfdc_offset_hist.sv
// Small register memory that keeps the receive byte offset applied to the
// last few frames, so software can see which offset each frame used.
// Assumes one write per frame start; read data comes from a register.
`timescale 1ns/100ps
`include "hmfdc_map.svh"
module hmfdc_offset_hist (
    input  wire logic       i_core_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_wr,
    input  wire logic [4:0] i_wr_data,
    input  wire logic [1:0] i_rd_addr,
    output logic      [4:0] o_rd_data
);
    typedef struct packed {
        logic [`HMFDC_HIST_DEPTH-1:0][4:0] mem;
        logic [1:0]                        wptr;
        logic [4:0]                        rd;
    } hmfdc_hist_type;

    hmfdc_hist_type st;
    hmfdc_hist_type next_st;

    always_comb begin
        next_st = st;
        if (i_wr) begin
            next_st.mem[st.wptr] = i_wr_data;
            next_st.wptr         = st.wptr + 2'h1;
        end
        next_st.rd = st.mem[i_rd_addr];
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_rd_data = st.rd;
endmodule

//--- rtl/hmfdc_top.sv
// APB register bank controlling the host MAC transmit path and the receive
// data FIFO alignment and frame skip.
// Assumes the MAC and FIFOs answer the handshakes below in the same clock.
`timescale 1ns/100ps
`include "hmfdc_map.svh"
module hmfdc_top (
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_tx_frame_active,
    input  wire logic        i_tx_status_full,
    input  wire logic        i_rx_frame_start,
    input  wire logic        i_rx_word_read,
    input  wire logic        i_rx_skip_done,
    output logic             o_tx_mac_enable,
    output logic             o_tx_hold,
    output logic             o_tx_status_flush,
    output logic             o_tx_data_flush,
    output logic             o_rx_skip_req,
    output logic       [4:0] o_rx_byte_offset,
    output logic             o_irq
);
    typedef struct packed {
        logic [4:0]                      rx_off_cfg;
        logic [4:0]                      rx_byte_offset;
        logic                            tx_enable;
        logic                            tx_stop;
        logic                            tx_overrun_permit;
        logic                            tx_status_flush;
        logic                            tx_data_flush;
        logic                            rx_frame_skip;
        hmfdc_pkg::hmfdc_tx_state_type   tx_state;
        hmfdc_pkg::hmfdc_skip_state_type skip_state;
        logic [`HMFDC_IRQ_W-1:0]         irq_sts;
        logic [`HMFDC_IRQ_W-1:0]         irq_mask;
        logic                            full_q;
        logic [31:0]                     prdata;
        logic                            pslverr;
    } hmfdc_state_type;

    hmfdc_state_type st;
    hmfdc_state_type next_st;
    logic [4:0]      hist_rd;

    // Applies the word part of the offset freely and the byte part as well.
    function automatic logic [4:0] next_offset(input logic [4:0] cur,
                                               input logic [4:0] cfg);
        next_offset = {cfg[4:2], cfg[1:0]};
    endfunction

    function automatic logic is_addr(input logic [11:0] a,
                                     input logic [11:0] off);
        is_addr = (a == off);
    endfunction

    hmfdc_offset_hist u_hist (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .i_wr       (i_rx_frame_start),
        .i_wr_data  (st.rx_byte_offset),
        .i_rd_addr  (i_pwdata[1:0]),
        .o_rd_data  (hist_rd)
    );

    logic access;
    logic setup;
    logic wr;
    logic rd;
    logic [`HMFDC_IRQ_W-1:0] ev;

    always_comb begin
        access  = i_psel && i_penable;
        setup   = i_psel && !i_penable;
        wr      = access && i_pwrite;
        rd      = access && !i_pwrite;
        ev      = '0;
        next_st = st;
        next_st.tx_status_flush = 1'b0;
        next_st.tx_data_flush   = 1'b0;
        next_st.full_q          = i_tx_status_full;

        // Status-full event ignores the overrun permit entirely.
        if (i_tx_status_full && !st.full_q) begin // RL7
            ev[`HMFDC_IRQ_STS_FULL] = 1'b1;
        end

        // The low offset bits are only legal to change with the receiver
        // halted, so both parts are taken at the next word read or frame start.
        if (i_rx_word_read || i_rx_frame_start) begin // RL3
            next_st.rx_byte_offset = next_offset(st.rx_byte_offset,
                                                 st.rx_off_cfg); // RL1
        end

        case (st.tx_state)
            hmfdc_pkg::HMFDC_TX_IDLE: begin
                if (st.tx_enable) begin
                    next_st.tx_state = hmfdc_pkg::HMFDC_TX_RUN; // RL8
                end
            end
            hmfdc_pkg::HMFDC_TX_RUN: begin
                if (st.tx_stop) begin
                    next_st.tx_state = hmfdc_pkg::HMFDC_TX_STOP;
                end else if (!st.tx_enable) begin
                    next_st.tx_state = hmfdc_pkg::HMFDC_TX_IDLE;
                end
            end
            hmfdc_pkg::HMFDC_TX_STOP: begin
                // The frame on the wire is allowed to finish first.
                if (!i_tx_frame_active) begin // RL10
                    next_st.tx_stop   = 1'b0; // RL10
                    next_st.tx_enable = 1'b0; // RL9
                    next_st.tx_state  = hmfdc_pkg::HMFDC_TX_IDLE;
                    ev[`HMFDC_IRQ_TX_STOPPED] = 1'b1;
                end
            end
            default: next_st.tx_state = hmfdc_pkg::HMFDC_TX_IDLE;
        endcase

        case (st.skip_state)
            hmfdc_pkg::HMFDC_SKIP_IDLE: begin
                if (st.rx_frame_skip) begin
                    next_st.skip_state = hmfdc_pkg::HMFDC_SKIP_BUSY;
                end
            end
            hmfdc_pkg::HMFDC_SKIP_BUSY: begin
                if (i_rx_skip_done) begin
                    next_st.rx_frame_skip = 1'b0; // RL12
                    next_st.skip_state    = hmfdc_pkg::HMFDC_SKIP_IDLE;
                    ev[`HMFDC_IRQ_SKIP_DONE] = 1'b1;
                end
            end
            default: next_st.skip_state = hmfdc_pkg::HMFDC_SKIP_IDLE;
        endcase

        // Read data and the error flag are settled in the setup cycle, so
        // they already stand at the zero-wait access edge of the master.
        next_st.pslverr = 1'b0;
        if (setup && !i_pwrite) begin
            next_st.prdata = 32'h0000_0000; // RL14
            if (is_addr(i_paddr, `HMFDC_RX_CFG_OFF)) begin
                next_st.prdata[`HMFDC_RXOFF_MSB:`HMFDC_RXOFF_LSB] =
                    st.rx_off_cfg;
                next_st.prdata[4:0] = hist_rd;
            end else if (is_addr(i_paddr, `HMFDC_TX_CFG_OFF)) begin
                next_st.prdata[`HMFDC_TX_OVR_PERMIT] = st.tx_overrun_permit;
                next_st.prdata[`HMFDC_TX_ENABLE]     = st.tx_enable;
                next_st.prdata[`HMFDC_TX_STOP]       = st.tx_stop;
            end else if (is_addr(i_paddr, `HMFDC_RECEIVE_DATAPATH_CONTROL_OFF)) begin
                next_st.prdata[`HMFDC_RX_SKIP] = st.rx_frame_skip;
            end else if (is_addr(i_paddr, `HMFDC_IRQ_STS_OFF)) begin
                next_st.prdata[`HMFDC_IRQ_W-1:0] = st.irq_sts;
            end else if (is_addr(i_paddr, `HMFDC_IRQ_MASK_OFF)) begin
                next_st.prdata[`HMFDC_IRQ_W-1:0] = st.irq_mask;
            end else begin
                next_st.pslverr = 1'b1;
            end
        end

        if (setup && i_pwrite &&
            !is_addr(i_paddr, `HMFDC_RX_CFG_OFF) &&
            !is_addr(i_paddr, `HMFDC_TX_CFG_OFF) &&
            !is_addr(i_paddr, `HMFDC_RECEIVE_DATAPATH_CONTROL_OFF) &&
            !is_addr(i_paddr, `HMFDC_IRQ_STS_OFF) &&
            !is_addr(i_paddr, `HMFDC_IRQ_MASK_OFF)) begin
            next_st.pslverr = 1'b1;
        end

        if (wr) begin
            if (is_addr(i_paddr, `HMFDC_RX_CFG_OFF)) begin
                next_st.rx_off_cfg =
                    i_pwdata[`HMFDC_RXOFF_MSB:`HMFDC_RXOFF_LSB];
            end else if (is_addr(i_paddr, `HMFDC_TX_CFG_OFF)) begin
                next_st.tx_status_flush =
                    i_pwdata[`HMFDC_TX_STS_FLUSH]; // RL4
                next_st.tx_data_flush =
                    i_pwdata[`HMFDC_TX_DAT_FLUSH]; // RL5
                next_st.tx_overrun_permit = i_pwdata[`HMFDC_TX_OVR_PERMIT];
                // Hardware clearing enable in the same cycle wins.
                if (st.tx_state != hmfdc_pkg::HMFDC_TX_STOP ||
                    i_tx_frame_active) begin
                    next_st.tx_enable = i_pwdata[`HMFDC_TX_ENABLE];
                end
                if (!st.tx_stop) begin // RL11
                    next_st.tx_stop = i_pwdata[`HMFDC_TX_STOP];
                end
            end else if (is_addr(i_paddr, `HMFDC_RECEIVE_DATAPATH_CONTROL_OFF)) begin
                if (i_pwdata[`HMFDC_RX_SKIP]) begin
                    next_st.rx_frame_skip = 1'b1; // RL12
                end
            end else if (is_addr(i_paddr, `HMFDC_IRQ_MASK_OFF)) begin
                next_st.irq_mask = i_pwdata[`HMFDC_IRQ_W-1:0];
            end
        end

        // A status read clears only the bits it reported, so an event that
        // arrives after the setup snapshot survives.
        if (rd && is_addr(i_paddr, `HMFDC_IRQ_STS_OFF)) begin
            next_st.irq_sts = (st.irq_sts &
                               ~st.prdata[`HMFDC_IRQ_W-1:0]) | ev;
        end else begin
            next_st.irq_sts = st.irq_sts | ev;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            st                   <= '0;
            st.rx_off_cfg        <= `HMFDC_RXOFF_RST;
            st.rx_byte_offset    <= `HMFDC_RXOFF_RST;
            st.irq_mask          <= `HMFDC_IRQ_MASK_RST;
            st.tx_state          <= hmfdc_pkg::HMFDC_TX_IDLE;
            st.skip_state        <= hmfdc_pkg::HMFDC_SKIP_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign o_prdata          = st.prdata;
    assign o_pslverr         = st.pslverr;
    assign o_pready          = 1'b1;
    assign o_tx_mac_enable   = st.tx_enable; // RL8
    // Without overrun permit a full status FIFO holds the transmitter.
    assign o_tx_hold         = i_tx_status_full &&
                               !st.tx_overrun_permit; // RL6
    assign o_tx_status_flush = st.tx_status_flush;
    assign o_tx_data_flush   = st.tx_data_flush;
    assign o_rx_skip_req     = st.rx_frame_skip; // RL12
    assign o_rx_byte_offset  = st.rx_byte_offset;
    assign o_irq             = |(st.irq_sts & st.irq_mask);
endmodule

//--- verification/hmfdc_top_props.sv
// Port-level assertions for the host MAC FIFO datapath control block.
// Assumes APB with pready always high; bound into hmfdc_top below.
`timescale 1ns/100ps
module hmfdc_chk (
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pslverr,
    input wire logic        i_tx_frame_active,
    input wire logic        i_tx_status_full,
    input wire logic        i_rx_frame_start,
    input wire logic        i_rx_word_read,
    input wire logic        i_rx_skip_done,
    input wire logic        o_tx_mac_enable,
    input wire logic        o_tx_hold,
    input wire logic        o_tx_status_flush,
    input wire logic        o_tx_data_flush,
    input wire logic        o_rx_skip_req,
    input wire logic [4:0]  o_rx_byte_offset
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    wire acc = i_psel && i_penable && i_pwrite;
    wire wr_tx = acc && (i_paddr == 12'h070);
    wire wr_dp = acc && (i_paddr == 12'h078);
    sequence s_flush_st;
        wr_tx && i_pwdata[15];
    endsequence
    sequence s_flush_dt;
        wr_tx && i_pwdata[14];
    endsequence
    a_status_flush_pulse: assert property (s_flush_st |=>
        o_tx_status_flush ##1 !o_tx_status_flush) else $error("sflush");
    a_data_flush_pulse: assert property (s_flush_dt |=>
        o_tx_data_flush ##1 !o_tx_data_flush) else $error("dflush");
    a_hold_needs_full: assert property (!i_tx_status_full |->
        !o_tx_hold) else $error("hold without full");
    a_enable_sets: assert property (wr_tx && i_pwdata[1] &&
        !i_pwdata[0] |=> o_tx_mac_enable) else $error("enable");
    a_frame_finishes: assert property (o_tx_mac_enable &&
        i_tx_frame_active && !wr_tx |=> o_tx_mac_enable)
        else $error("enable dropped mid frame");
    a_skip_sets: assert property (wr_dp && i_pwdata[31] |=>
        o_rx_skip_req) else $error("skip not set");
    a_skip_holds: assert property (o_rx_skip_req &&
        !i_rx_skip_done |=> o_rx_skip_req) else $error("skip dropped");
    a_skip_clears: assert property (o_rx_skip_req && i_rx_skip_done
        && !wr_dp |=> !o_rx_skip_req) else $error("skip stuck");
    a_offset_steady: assert property (!i_rx_word_read &&
        !i_rx_frame_start |=> $stable(o_rx_byte_offset))
        else $error("offset moved");
    a_unmapped_err: assert property (i_psel && i_penable &&
        i_paddr == 12'h100 |-> o_pslverr) else $error("no slverr");
endmodule
bind hmfdc_top hmfdc_chk u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pslverr(o_pslverr),
    .i_tx_frame_active(i_tx_frame_active),
    .i_tx_status_full(i_tx_status_full),
    .i_rx_frame_start(i_rx_frame_start), .i_rx_word_read(i_rx_word_read),
    .i_rx_skip_done(i_rx_skip_done), .o_tx_mac_enable(o_tx_mac_enable),
    .o_tx_hold(o_tx_hold), .o_tx_status_flush(o_tx_status_flush),
    .o_tx_data_flush(o_tx_data_flush), .o_rx_skip_req(o_rx_skip_req),
    .o_rx_byte_offset(o_rx_byte_offset));

//--- verification/hmfdc_mac_model.sv
// Behavioural model of the host MAC and receive FIFO beside the block.
// Assumes one clock; the bench decides when frame data is queued.
`timescale 1ns/100ps
module hmfdc_mac_model #(
    parameter int SKIP_LAT = 8
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_tx_mac_enable,
    input wire logic i_frame_pending,
    input wire logic i_rx_skip_req,
    output logic     o_tx_frame_active,
    output logic     o_rx_skip_done
);
    logic [7:0] cnt;
    // A frame only runs while the transmitter is enabled.
    assign o_tx_frame_active = i_tx_mac_enable & i_frame_pending;
    // The skip takes several cycles, so the busy bit can be seen high.
    always_ff @(posedge i_core_clk) begin
        o_rx_skip_done <= 1'b0;
        if (!i_nrst) begin
            cnt <= 8'h00;
        end else if (i_rx_skip_req && !o_rx_skip_done) begin
            cnt <= (cnt == 8'(SKIP_LAT - 1)) ? 8'h00 : cnt + 8'h01;
            o_rx_skip_done <= (cnt == 8'(SKIP_LAT - 1));
        end
    end
endmodule

//--- verification/tb_host_mac_fifo_datapath_control.sv
// Self-checking bench for the host MAC FIFO datapath control block.
// Assumes APB whose read data and error stand at the pready edge.
`timescale 1ns/100ps
module tb_host_mac_fifo_datapath_control;
    logic clk, nrst, psel, pen, pwr, full, fs, wrd, pend, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic pready, pslverr, fact, sdone, txen, hold, sfl, dfl, sreq, irq;
    logic [4:0] offs;
    int err_count = 0;
    int n_compared = 0;
    hmfdc_top uut (.i_core_clk(clk), .i_nrst(nrst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_tx_frame_active(fact),
        .i_tx_status_full(full), .i_rx_frame_start(fs),
        .i_rx_word_read(wrd), .i_rx_skip_done(sdone),
        .o_tx_mac_enable(txen), .o_tx_hold(hold),
        .o_tx_status_flush(sfl), .o_tx_data_flush(dfl),
        .o_rx_skip_req(sreq), .o_rx_byte_offset(offs), .o_irq(irq));
    hmfdc_mac_model mac (.i_core_clk(clk), .i_nrst(nrst),
        .i_tx_mac_enable(txen), .i_frame_pending(pend),
        .i_rx_skip_req(sreq), .o_tx_frame_active(fact),
        .o_rx_skip_done(sdone));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
            err_count++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        // The response is taken at the edge where pready is sampled high.
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic t_regs;
        apb(0, 12'h070, 0); chk(rdata, 32'h0);
        apb(0, 12'h078, 0); chk(rdata, 32'h0);
        apb(0, 12'h100, 0); chk(32'(rerr), 32'h1);
        apb(1, 12'h070, 32'hFFFF_C000);
        #1 chk(32'({sfl, dfl}), 32'h3);
        @(posedge clk);
        #1 chk(32'({sfl, dfl}), 32'h0);
        apb(0, 12'h070, 0); chk(rdata, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_stop;
        apb(1, 12'h0C4, 32'h2);
        pend <= 1'b1;
        apb(1, 12'h070, 32'h2);
        #1 chk(32'(fact), 32'h1);
        apb(1, 12'h070, 32'h3);
        apb(1, 12'h070, 32'h2);
        apb(0, 12'h070, 0); chk(rdata, 32'h3);
        pend <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(32'({txen, irq}), 32'h1);
        apb(0, 12'h070, 0); chk(rdata, 32'h0);
        apb(0, 12'h0C0, 0); chk(rdata, 32'h2);
        #1 chk(32'(irq), 32'h0);
        $display("test stop done");
    endtask
    task automatic t_overrun;
        apb(1, 12'h0C4, 32'h0);
        full <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk({hold, irq}, 32'h2);
        apb(0, 12'h0C0, 0); chk(rdata, 32'h1);
        apb(1, 12'h070, 32'h4);
        #1 chk(32'(hold), 32'h0);
        apb(1, 12'h0C4, 32'h1);
        full <= 1'b0;
        @(posedge clk) full <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(32'(irq), 32'h1);
        apb(0, 12'h0C0, 0); chk(rdata, 32'h1);
        #1 chk(32'(irq), 32'h0);
        full <= 1'b0;
        $display("test overrun done");
    endtask
    task automatic t_skip;
        apb(1, 12'h078, 32'h8000_0000);
        apb(0, 12'h078, 0); chk(rdata, 32'h8000_0000);
        for (int i = 0; i < 30 && sreq; i++) @(posedge clk);
        apb(0, 12'h078, 0); chk(rdata, 32'h0);
        $display("test skip done");
    endtask
    task automatic t_offset;
        logic [4:0] v;
        // Receive path is idle, so the low offset bits may change.
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 5'h1F : (i == 1) ? 5'h08 : 5'h00;
            apb(1, 12'h06C, 32'hFFFF_E0E0 | {19'h0, v, 8'h00});
            @(posedge clk);
            if (i == 2) fs <= 1'b1;
            else wrd <= 1'b1;
            @(posedge clk);
            fs <= 1'b0;
            wrd <= 1'b0;
            #1 chk(32'(offs), 32'(v));
            apb(0, 12'h06C, 0);
            chk(rdata & 32'hFFFF_FFE0, {19'h0, v, 8'h00});
        end
        $display("test offset done");
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #200000;
        err_count++;
        report_and_stop;
    end
    initial begin
        {nrst, psel, pen, pwr, full, fs, wrd, pend} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_stop;
        t_overrun;
        t_skip;
        t_offset;
        report_and_stop;
    end
endmodule
